/* shared/asp_pkg.sv */
/*
 * asp_pkg: register map, field positions, reset values and codes of the
 * slot-based audio serial port.
 * Assumes a 32-bit word-addressed register bus with byte addresses.
 */
package asp_pkg;
    localparam int NSLOT = 4;

    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CLKDIV = 8'h04;
    localparam logic [7:0] ADR_SLOT = 8'h08;
    localparam logic [7:0] ADR_WARN = 8'h0c;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_IRQEN = 8'h14;
    localparam logic [7:0] ADR_TXFIFO = 8'h18;
    localparam logic [7:0] ADR_RXFIFO = 8'h1c;
    localparam logic [7:0] ADR_RXDR = 8'h20;
    localparam logic [7:0] ADR_TXDR = 8'h30;

    // reset values and writable bits
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CLKDIV_RST = 32'h0000_0000;
    localparam logic [31:0] SLOT_RST = 32'h0000_0000;
    localparam logic [31:0] WARN_RST = 32'h0000_0000;
    localparam logic [31:0] IRQEN_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_03ff;
    localparam logic [31:0] CLKDIV_MASK = 32'h0000_7fff;
    localparam logic [31:0] SLOT_MASK = 32'h0000_ffff;
    localparam logic [31:0] WARN_MASK = 32'h0000_1f1f;
    localparam logic [31:0] IRQEN_MASK = 32'h0000_000f;

    // control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_SYNC = 1;
    localparam int CTRL_NET = 2;
    localparam int CTRL_SCS = 3;
    localparam int CTRL_W16 = 5;
    localparam int CTRL_SRC = 6;
    localparam int CTRL_FSL = 7;
    localparam int CLK_BIT_CLOCK_DIVIDER = 0;
    localparam int CLK_FRAME_CLOCK_DIVIDER = 8;
    localparam int SLOT_RXSA = 0;
    localparam int SLOT_TXSA = 4;
    localparam int SLOT_RXDSA = 8;
    localparam int SLOT_TXDSA = 12;
    localparam int WARN_RX = 0;
    localparam int WARN_TX = 8;

    // pending flag positions
    localparam int PND_RXO = 0;
    localparam int PND_RXW = 1;
    localparam int PND_TXU = 2;
    localparam int PND_TXW = 3;

    // long frame sync lengths in bit clocks
    localparam logic [4:0] FSL_LEN6 = 5'h06;
    localparam logic [4:0] FSL_LEN13 = 5'h0d;
    localparam logic [4:0] FSL_LEN14 = 5'h0e;
    localparam logic [4:0] FSL_LEN15 = 5'h0f;
    localparam logic [4:0] FSL_LEN16 = 5'h10;

    function automatic logic [4:0] fsl_len(input logic [2:0] code);
        unique case (code)
            3'h0: fsl_len = FSL_LEN6;
            3'h1: fsl_len = FSL_LEN13;
            3'h2: fsl_len = FSL_LEN14;
            3'h3: fsl_len = FSL_LEN15;
            default: fsl_len = FSL_LEN16;
        endcase
    endfunction
endpackage

/* hw/asp_divider.sv */
/*
 * asp_divider: counter that divides a tick stream by ratio plus one.
 * Assumes en_i is a one-cycle tick in the clk_i domain.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_divider #(
    parameter int W = 8
) (
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [W-1:0] ratio_i,
    // result
    output logic tick_o,
    output logic [W-1:0] cnt_o
);
    logic [W-1:0] cnt_reg;

    assign tick_o = en_i && (cnt_reg >= ratio_i);
    assign cnt_o = cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i || tick_o) begin
            cnt_reg <= '0;
        end else if (en_i) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* hw/asp_dma_slot.sv */
/*
 * asp_dma_slot: receive and transmit holding registers of one slot.
 * Assumes loads and takes are one-cycle pulses; a set beats a clear.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_dma_slot (
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // receive holding
    input wire logic rx_load_i,
    input wire logic [15:0] rx_word_i,
    input wire logic rx_take_i,
    output logic [15:0] rx_data_o,
    output logic rx_full_o,
    // transmit holding
    input wire logic tx_write_i,
    input wire logic [15:0] tx_word_i,
    input wire logic tx_take_i,
    output logic [15:0] tx_data_o,
    output logic tx_full_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_o <= 16'h0000;
            rx_full_o <= 1'b0;
        end else if (rx_load_i) begin
            // overwrite even when still full
            rx_data_o <= rx_word_i;
            rx_full_o <= 1'b1;
        end else if (rx_take_i) begin
            rx_full_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o <= 16'h0000;
            tx_full_o <= 1'b0;
        end else if (tx_write_i) begin
            tx_data_o <= tx_word_i;
            tx_full_o <= 1'b1;
        end else if (tx_take_i) begin
            // data kept, so an empty take resends it
            tx_full_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* hw/asp_audio_serial_port.sv */
/*
 * asp_audio_serial_port: slot-based audio serial port with Wishbone
 * registers, transmit and receive FIFOs, per-slot DMA holding registers,
 * clock and frame sync generation and auxiliary frame syncs.
 * Assumes all inputs synchronous to clk_i; source clocks arrive as ticks.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_audio_serial_port
    import asp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // prescaler input clocks as ticks
    input wire logic aux_clk_tick_i,
    input wire logic pll_clk_tick_i,
    // serial link
    output logic sck_o,
    output logic tx_frame_sync_o,
    output logic serial_tx_data_pin_o,
    output logic serial_tx_data_pin_oe_o,
    input wire logic serial_rx_data_pin_i,
    input wire logic rx_bit_clock_i,
    output logic rx_bit_clock_o,
    output logic rx_bit_clock_oe_o,
    input wire logic rx_frame_sync_i,
    output logic rx_frame_sync_o,
    output logic rx_frame_sync_oe_o,
    // system side
    output logic wakeup_frame_sync_o,
    output logic irq_o,
    output logic [3:0] rx_dma_req_o,
    output logic [3:0] tx_dma_req_o
);
    localparam int PW = $clog2(FIFO_DEPTH);

    // registers
    logic [31:0] ctrl_reg;
    logic [31:0] clkdiv_reg;
    logic [31:0] slot_reg;
    logic [31:0] warn_reg;
    logic [31:0] irqen_reg;
    logic [3:0] pend_reg;
    logic [3:0] pend_next;
    logic [31:0] rd_mux;

    // fifo storage and pointers
    logic [15:0] txf [FIFO_DEPTH];
    logic [15:0] rxf [FIFO_DEPTH];
    logic [PW-1:0] txwp_reg;
    logic [PW-1:0] txrp_reg;
    logic [PW-1:0] rxwp_reg;
    logic [PW-1:0] rxrp_reg;
    logic [PW:0] txcnt_reg;
    logic [PW:0] rxcnt_reg;

    // link state
    logic [15:0] txsh_reg;
    logic [15:0] rxsh_reg;
    logic [6:0] rxpos_reg;
    logic rxlive_reg;
    logic rxc_q_reg;
    logic rxfs_q_reg;
    logic frame_live_reg;

    // holding registers
    logic [15:0] hrx [NSLOT];
    logic [15:0] htx [NSLOT];
    logic [3:0] hrx_full;
    logic [3:0] htx_full;
    logic [3:0] rx_load;
    logic [3:0] rx_take;
    logic [3:0] tx_write;
    logic [3:0] tx_take;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // control fields
    wire en = ctrl_reg[CTRL_EN];
    wire sync_m = ctrl_reg[CTRL_SYNC];
    wire net_m = ctrl_reg[CTRL_NET];
    wire [1:0] slot_count_select = ctrl_reg[CTRL_SCS +: 2];
    wire w16 = ctrl_reg[CTRL_W16];
    wire src_sel = ctrl_reg[CTRL_SRC];
    wire [2:0] frame_sync_length = ctrl_reg[CTRL_FSL +: 3];
    wire [7:0] bit_clock_divider = clkdiv_reg[CLK_BIT_CLOCK_DIVIDER +: 8];
    wire [6:0] frame_clock_divider = clkdiv_reg[CLK_FRAME_CLOCK_DIVIDER +: 7];
    wire [3:0] rxsa = slot_reg[SLOT_RXSA +: 4];
    wire [3:0] txsa = slot_reg[SLOT_TXSA +: 4];
    wire [3:0] rxdsa = slot_reg[SLOT_RXDSA +: 4];
    wire [3:0] txdsa = slot_reg[SLOT_TXDSA +: 4];
    wire [7:0] rxw = {3'h0, warn_reg[WARN_RX +: 5]};
    wire [7:0] txw = {3'h0, warn_reg[WARN_TX +: 5]};

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;
    wire bus_rd = bus_req & ~wb_we_i;
    wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
    wire [1:0] adr_idx = adr[3:2];
    wire hit_rxdr = adr[7:4] == ADR_RXDR[7:4];
    wire hit_txdr = adr[7:4] == ADR_TXDR[7:4];
    wire lo_lanes = wb_sel_i[0] | wb_sel_i[1];

    // bit and frame clock prescalers
    wire src_tick = src_sel ? pll_clk_tick_i : aux_clk_tick_i;
    wire bit_tick;
    wire [7:0] bcnt;
    wire frame_tick;
    wire [6:0] pos;

    asp_divider #(.W(8)) u_bitdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(~en),
        .en_i(src_tick),
        .ratio_i(bit_clock_divider),
        .tick_o(bit_tick),
        .cnt_o(bcnt)
    );

    asp_divider #(.W(7)) u_framediv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(~en),
        .en_i(bit_tick),
        .ratio_i(frame_clock_divider),
        .tick_o(frame_tick),
        .cnt_o(pos)
    );

    wire half_tick = src_tick & (bcnt == (bit_clock_divider >> 1));
    wire [6:0] pos_nxt = frame_tick ? 7'h00 : pos + 7'h01;
    wire frame_start = bit_tick & (pos_nxt == 7'h00);
    wire live = frame_live_reg | frame_start;

    // transmit slot position
    wire [1:0] slot_max = net_m ? slot_count_select : 2'b00;
    wire [3:0] bmax = w16 ? 4'hf : 4'h7;
    wire [3:0] tslot = w16 ? {1'b0, pos_nxt[6:4]} : pos_nxt[6:3];
    wire [3:0] tbit = w16 ? pos_nxt[3:0] : {1'b0, pos_nxt[2:0]};
    wire tslot_ok = live & (tslot <= {2'b00, slot_max});
    wire [1:0] ts = tslot[1:0];
    wire tx_act = tslot_ok & txsa[ts];
    wire tx_load = bit_tick & tx_act & (tbit == 4'h0);
    wire tx_dma = txdsa[ts];
    wire tx_pop = tx_load & ~tx_dma;
    wire tx_empty = txcnt_reg == '0;
    wire tx_under = tx_pop & tx_empty;
    wire [PW-1:0] txrp_prev = txrp_reg - 1'b1;
    wire [15:0] tx_fifo_word = tx_under ? txf[txrp_prev] : txf[txrp_reg];
    wire [15:0] tx_word = tx_dma ? htx[ts] : tx_fifo_word;
    wire [15:0] tx_src = tx_load ? tx_word : txsh_reg;
    wire tx_bit = w16 ? tx_src[15] : tx_src[7];
    wire fs_next = en & live & (pos_nxt < {2'b00, fsl_len(frame_sync_length)});

    // receive clocking: shared or external
    wire ext_fall = rxc_q_reg & ~rx_bit_clock_i;
    wire ext_fs = ~rxfs_q_reg & rx_frame_sync_i;
    wire rx_fs = sync_m ? frame_start : ext_fs;
    wire rx_smp = sync_m ? half_tick : ext_fall;
    wire [6:0] rpos = rx_fs ? 7'h00 : rxpos_reg;
    wire [3:0] rslot = w16 ? {1'b0, rpos[6:4]} : rpos[6:3];
    wire [3:0] rbit = w16 ? rpos[3:0] : {1'b0, rpos[2:0]};
    wire [1:0] rs = rslot[1:0];
    wire rslot_ok = rslot <= {2'b00, slot_max};
    wire rx_done = rx_smp & (rxlive_reg | rx_fs) & (rbit == bmax)
                   & rslot_ok & rxsa[rs];
    wire [15:0] rx_raw = {rxsh_reg[14:0], serial_rx_data_pin_i};
    wire [15:0] rx_word = w16 ? rx_raw : {8'h00, rx_raw[7:0]};
    wire rx_to_dma = rx_done & rxdsa[rs];
    wire rx_push = rx_done & ~rxdsa[rs];
    wire rx_full = rxcnt_reg == (PW + 1)'(FIFO_DEPTH);
    wire rx_over = rx_push & rx_full;
    wire tx_push = bus_wr & (adr == ADR_TXFIFO) & lo_lanes;
    wire rx_pop = bus_rd & (adr == ADR_RXFIFO) & (rxcnt_reg != '0);

    // fifo levels and pending events
    wire [7:0] txc8 = 8'(txcnt_reg);
    wire [7:0] rxc8 = 8'(rxcnt_reg);
    wire rxw_set = (rxc8 > rxw) & ~rx_over;
    wire txw_set = en & (txc8 <= txw) & ~tx_under;
    wire [3:0] pend_set = {txw_set, tx_under, rxw_set, rx_over};
    wire [3:0] pend_clr = (bus_wr & (adr == ADR_STATUS) & wb_sel_i[0])
                          ? wb_dat_i[3:0] : 4'h0;
    assign pend_next = (pend_reg & ~pend_clr) | pend_set;

    // per-slot holding registers
    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
        assign rx_load[g] = rx_to_dma & (rs == g);
        assign rx_take[g] = bus_rd & hit_rxdr & (adr_idx == g);
        assign tx_write[g] = bus_wr & hit_txdr & (adr_idx == g) & lo_lanes;
        assign tx_take[g] = tx_load & tx_dma & (ts == g);

        asp_dma_slot u_slot (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .rx_load_i(rx_load[g]),
            .rx_word_i(rx_word),
            .rx_take_i(rx_take[g]),
            .rx_data_o(hrx[g]),
            .rx_full_o(hrx_full[g]),
            .tx_write_i(tx_write[g]),
            .tx_word_i(wb_dat_i[15:0]),
            .tx_take_i(tx_take[g]),
            .tx_data_o(htx[g]),
            .tx_full_o(htx_full[g])
        );
    end

    // read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_rxdr) begin
            rd_mux = {16'h0000, hrx[adr_idx]};
        end else if (hit_txdr) begin
            rd_mux = {16'h0000, htx[adr_idx]};
        end else begin
            unique case (adr)
                ADR_CTRL: rd_mux = ctrl_reg;
                ADR_CLKDIV: rd_mux = clkdiv_reg;
                ADR_SLOT: rd_mux = slot_reg;
                ADR_WARN: rd_mux = warn_reg;
                ADR_IRQEN: rd_mux = irqen_reg;
                ADR_STATUS: rd_mux = {rxc8, txc8, htx_full, hrx_full,
                                      4'h0, pend_reg};
                ADR_RXFIFO: rd_mux = {16'h0000, rxf[rxrp_reg]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // bus answer: one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            clkdiv_reg <= CLKDIV_RST;
            slot_reg <= SLOT_RST;
            warn_reg <= WARN_RST;
            irqen_reg <= IRQEN_RST;
        end else if (bus_wr) begin
            unique case (adr)
                ADR_CTRL: ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i)
                                      & CTRL_MASK;
                ADR_CLKDIV: clkdiv_reg <= merge(clkdiv_reg, wb_dat_i,
                                                wb_sel_i) & CLKDIV_MASK;
                ADR_SLOT: slot_reg <= merge(slot_reg, wb_dat_i, wb_sel_i)
                                      & SLOT_MASK;
                ADR_WARN: warn_reg <= merge(warn_reg, wb_dat_i, wb_sel_i)
                                      & WARN_MASK;
                ADR_IRQEN: irqen_reg <= merge(irqen_reg, wb_dat_i, wb_sel_i)
                                        & IRQEN_MASK;
                default: ;
            endcase
        end
    end

    // pending flags, interrupt and dma requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 4'h0;
            irq_o <= 1'b0;
            rx_dma_req_o <= 4'h0;
            tx_dma_req_o <= 4'h0;
        end else begin
            pend_reg <= pend_next;
            irq_o <= |(pend_reg & irqen_reg[3:0]);
            rx_dma_req_o <= hrx_full & rxdsa;
            tx_dma_req_o <= ~htx_full & txdsa & {4{en}};
        end
    end

    // transmit fifo
    always_ff @(posedge clk_i) begin
        if (tx_push) begin
            txf[txwp_reg] <= wb_dat_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txwp_reg <= '0;
            txrp_reg <= '0;
            txcnt_reg <= '0;
        end else begin
            if (tx_push) begin
                txwp_reg <= txwp_reg + 1'b1;
            end
            if (tx_pop & ~tx_empty) begin
                txrp_reg <= txrp_reg + 1'b1;
            end
            if (tx_push & ~(tx_pop & ~tx_empty)) begin
                if (txcnt_reg != (PW + 1)'(FIFO_DEPTH)) begin
                    txcnt_reg <= txcnt_reg + 1'b1;
                end
            end else if (~tx_push & tx_pop & ~tx_empty) begin
                txcnt_reg <= txcnt_reg - 1'b1;
            end
        end
    end

    // receive fifo
    always_ff @(posedge clk_i) begin
        if (rx_push & ~rx_full) begin
            rxf[rxwp_reg] <= rx_word;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxwp_reg <= '0;
            rxrp_reg <= '0;
            rxcnt_reg <= '0;
        end else begin
            if (rx_push & ~rx_full) begin
                rxwp_reg <= rxwp_reg + 1'b1;
            end
            if (rx_pop) begin
                rxrp_reg <= rxrp_reg + 1'b1;
            end
            if ((rx_push & ~rx_full) & ~rx_pop) begin
                rxcnt_reg <= rxcnt_reg + 1'b1;
            end else if (~(rx_push & ~rx_full) & rx_pop) begin
                rxcnt_reg <= rxcnt_reg - 1'b1;
            end
        end
    end

    // transmit pins, frame syncs and bit clock
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            sck_o <= 1'b0;
            tx_frame_sync_o <= 1'b0;
            wakeup_frame_sync_o <= 1'b0;
            serial_tx_data_pin_o <= 1'b0;
            serial_tx_data_pin_oe_o <= 1'b0;
            txsh_reg <= 16'h0000;
            frame_live_reg <= 1'b0;
            rx_bit_clock_o <= 1'b0;
            rx_frame_sync_o <= 1'b0;
            rx_bit_clock_oe_o <= 1'b0;
            rx_frame_sync_oe_o <= 1'b0;
        end else begin
            rx_bit_clock_oe_o <= sync_m & net_m;
            rx_frame_sync_oe_o <= sync_m & net_m;
            frame_live_reg <= live;
            if (bit_tick) begin
                sck_o <= 1'b1;
            end else if (half_tick) begin
                sck_o <= 1'b0;
            end
            if (bit_tick) begin
                tx_frame_sync_o <= fs_next;
                wakeup_frame_sync_o <= fs_next;
                rx_bit_clock_o <= sync_m & net_m & tslot_ok
                                  & (tslot == 4'h1) & (tbit == 4'h0);
                rx_frame_sync_o <= sync_m & net_m & tslot_ok
                                   & (tslot == 4'h2) & (tbit == 4'h0);
                serial_tx_data_pin_oe_o <= tx_act;
                serial_tx_data_pin_o <= tx_act & tx_bit;
                txsh_reg <= {tx_src[14:0], 1'b0};
            end
        end
    end

    // receive shift register and slot position
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            rxsh_reg <= 16'h0000;
            rxpos_reg <= 7'h00;
            rxlive_reg <= 1'b0;
            rxc_q_reg <= 1'b0;
            rxfs_q_reg <= 1'b0;
        end else begin
            rxc_q_reg <= rx_bit_clock_i;
            rxfs_q_reg <= rx_frame_sync_i;
            if (rx_fs) begin
                rxlive_reg <= 1'b1;
            end
            if (rx_smp) begin
                rxsh_reg <= rx_raw;
                rxpos_reg <= (rpos == 7'h7f) ? rpos : rpos + 7'h01;
            end else begin
                rxpos_reg <= rpos;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/asp_audio_serial_port_props.sv */
/* port checks of the audio serial port; bound to its top module. */
`timescale 1ns/1ps
`default_nettype none
module asp_audio_serial_port_props (
    // system and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    // link and requests
    input wire logic sck_o,
    input wire logic tx_frame_sync_o,
    input wire logic serial_tx_data_pin_o,
    input wire logic serial_tx_data_pin_oe_o,
    input wire logic rx_bit_clock_o,
    input wire logic rx_frame_sync_o,
    input wire logic rx_bit_clock_oe_o,
    input wire logic rx_frame_sync_oe_o,
    input wire logic wakeup_frame_sync_o,
    input wire logic [3:0] rx_dma_req_o,
    input wire logic [3:0] tx_dma_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] fs_len_reg;
    logic [6:0] bit_pos_reg;
    // sync length and bit position counted in bit clock rises
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_frame_sync_o) fs_len_reg <= 5'h00;
        else if ($rose(sck_o)) fs_len_reg <= fs_len_reg + 5'h01;
        if (rst_i) bit_pos_reg <= 7'h00;
        else if ($rose(sck_o))
            bit_pos_reg <= $rose(tx_frame_sync_o) ? 7'h00 : bit_pos_reg + 7'h01;
    end
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    chk_ack_next: assert property (s_wb_req |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_fs_len: assert property ($fell(tx_frame_sync_o) |->
        fs_len_reg inside {5'h06, 5'h0d, 5'h0e, 5'h0f, 5'h10})
        else $error("frame sync length not allowed");
    chk_aux_slot1: assert property ($rose(rx_bit_clock_o) |->
        bit_pos_reg inside {7'h07, 7'h0f}) else $error("aux sync 1 misplaced");
    chk_aux_slot2: assert property ($rose(rx_frame_sync_o) |->
        bit_pos_reg inside {7'h0f, 7'h1f}) else $error("aux sync 2 misplaced");
    chk_tx_shift: assert property ($changed(serial_tx_data_pin_o) |->
        $rose(sck_o)) else $error("tx data moved off rising bit clock");
    chk_wakeup_copy: assert property ($rose(tx_frame_sync_o) |->
        ##[0:1] wakeup_frame_sync_o) else $error("wake-up sync missing");
    chk_tx_oe: assert property (serial_tx_data_pin_o |->
        serial_tx_data_pin_oe_o) else $error("tx data undriven");
    chk_aux_oe: assert property ($rose(rx_bit_clock_o)
        || $rose(rx_frame_sync_o) |-> rx_bit_clock_oe_o && rx_frame_sync_oe_o)
        else $error("aux sync undriven");
    chk_txreq_drop: assert property ($fell(tx_dma_req_o[0]) |->
        $past(wb_stb_i && wb_we_i && wb_adr_i == 8'h30)
        || $past(wb_stb_i && wb_we_i && wb_adr_i == 8'h30, 2))
        else $error("tx request dropped without holding write");
    chk_rxreq_rise: assert property ($rose(rx_dma_req_o[0]) |->
        !sck_o && ($past(sck_o) || $past(sck_o, 2)))
        else $error("rx request not at falling bit clock");
endmodule
bind asp_audio_serial_port asp_audio_serial_port_props u_props (.clk_i,
    .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .sck_o,
    .tx_frame_sync_o, .serial_tx_data_pin_o, .rx_bit_clock_o,
    .rx_frame_sync_o, .wakeup_frame_sync_o, .rx_dma_req_o, .tx_dma_req_o,
    .serial_tx_data_pin_oe_o, .rx_bit_clock_oe_o, .rx_frame_sync_oe_o);
`default_nettype wire

/* dv/asp_codec_model.sv */
/* slot 0 codec model; follows bit clock and frame sync of the port. */
`timescale 1ns/1ps
`default_nettype none
module asp_codec_model (
    // link
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic fs_i,
    input wire logic tx_i,
    input wire logic [7:0] word_i,
    output logic rx_o,
    output logic [7:0] heard_o
);
    logic sck_q = 1'b0;
    logic fs_q = 1'b0;
    int pos = 99;
    initial rx_o = 1'b0;
    initial heard_o = 8'h00;
    always @(posedge clk_i) begin
        sck_q <= sck_i;
        fs_q <= fs_i;
        if (sck_i && !sck_q) begin
            pos = (fs_i && !fs_q) ? 0 : pos + 1;
            rx_o <= (pos < 8) ? word_i[7 - pos] : !rx_o;
        end
        if (!sck_i && sck_q && pos < 8) heard_o[7 - pos] <= tx_i;
    end
endmodule
`default_nettype wire

/* dv/tb_audio_slot_serial_port.sv */
/* bench of the audio port: bus master, codec model; clk_i at 100 MHz. */
`timescale 1ns/1ps
`default_nettype none
module tb_audio_slot_serial_port import asp_pkg::*;;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, aux_clk_tick_i = 1'b0, pll_clk_tick_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, tx = 8'h00, word = 8'h00, heard;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, ctrl, exp_q[$], msk_q[$];
    logic wb_ack_o, sck_o, fs, txd, rxd, irq_o;
    logic [3:0] rx_dma_req_o, tx_dma_req_o;
    logic [7:0] regs[6] = '{ADR_CTRL, ADR_CLKDIV, ADR_SLOT, ADR_STATUS,
        ADR_IRQEN, 8'h40};
    int num_errors = 0, samples_checked = 0, tcnt = 0;
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tcnt <= tcnt + 1;
        aux_clk_tick_i <= (tcnt % 8 == 0);
        pll_clk_tick_i <= (tcnt % 2 == 0);
    end
    asp_audio_serial_port uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aux_clk_tick_i(aux_clk_tick_i),
        .pll_clk_tick_i(pll_clk_tick_i), .sck_o(sck_o), .tx_frame_sync_o(fs),
        .serial_tx_data_pin_o(txd), .serial_tx_data_pin_oe_o(),
        .serial_rx_data_pin_i(rxd), .rx_bit_clock_i(1'b0), .rx_bit_clock_o(),
        .rx_bit_clock_oe_o(), .rx_frame_sync_i(1'b0), .rx_frame_sync_o(),
        .rx_frame_sync_oe_o(), .wakeup_frame_sync_o(), .irq_o(irq_o),
        .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o));
    asp_codec_model u_codec (.clk_i(clk_i), .sck_i(sck_o), .fs_i(fs),
        .tx_i(txd), .word_i(word), .rx_o(rxd), .heard_o(heard));
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, m, s);
        samples_checked++;
        if ((s & m) !== (e & m)) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e & m, s & m);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, m);
        int k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= we ? d : 32'h0;
        if (!we) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            summarize();
        end
    endtask
    // read results are compared in order as acks appear
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            cmp("rdata", exp_q.pop_front(), msk_q.pop_front(), wb_dat_o);
    task automatic reset_dut();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    initial begin
        #500_000;
        num_errors++;
        summarize();
    end
    initial begin
        int k;
        void'($urandom(23713));
        reset_dut();
        foreach (regs[i]) wb(1'b0, regs[i], 32'h0, 32'hffff_ffff);
        ctrl = $urandom;
        wb(1'b1, ADR_CLKDIV, ctrl, 32'h0);
        wb(1'b0, ADR_CLKDIV, ctrl & CLKDIV_MASK, 32'hffff_ffff);
        for (int c = 0; c < 5; c++) begin
            reset_dut();
            tx = 8'($urandom);
            word = 8'($urandom);
            wb(1'b1, ADR_CLKDIV, 32'h0000_1f03, 32'h0);
            wb(1'b1, ADR_SLOT, 32'h0000_1111, 32'h0);
            wb(1'b1, ADR_TXDR, {24'h0, tx}, 32'h0);
            ctrl = {22'h0, 3'(c), c[0], 6'h1f};
            wb(1'b1, ADR_CTRL, ctrl, 32'h0);
            k = 0;
            while (rx_dma_req_o[0] !== 1'b1 && k < 4000) begin
                @(posedge clk_i);
                k++;
            end
            if (k >= 4000) num_errors++;
            cmp("txreq", 32'h1, 32'h1, {28'h0, tx_dma_req_o});
            wb(1'b0, ADR_RXDR, {24'h0, word}, 32'hff);
            cmp("heard", {24'h0, tx}, 32'hff, {24'h0, heard});
            wb(1'b1, ADR_TXDR, {24'h0, tx}, 32'h0);
            wb(1'b1, ADR_IRQEN, 32'h8, 32'h0);
            repeat (2) @(posedge clk_i);
            cmp("irq", 32'h1, 32'h1, {31'h0, irq_o});
            wb(1'b0, ADR_STATUS, 32'h8, 32'h8);
            wb(1'b1, ADR_IRQEN, 32'h0, 32'h0);
            repeat (2) @(posedge clk_i);
            cmp("irq", 32'h0, 32'h1, {31'h0, irq_o});
        end
        summarize();
    end
endmodule
`default_nettype wire
